//--- srvc_pkg.sv
`default_nettype none
package srvc_pkg;
	// ----------------------------------------
	// Bus and register geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NUM_REGS = 13;

	localparam logic [7:0] OFF_FORCE_CTRL = 8'h08;
	localparam logic [7:0] OFF_REF_DOUBLER_CFG = 8'h09;
	localparam logic [7:0] OFF_FIXED_CFG_A = 8'h0a;
	localparam logic [7:0] OFF_POST_REF_DIVIDER = 8'h0b;
	localparam logic [7:0] OFF_PRE_REF_DIVIDER = 8'h0c;
	localparam logic [7:0] OFF_FIXED_CFG_B = 8'h0d;
	localparam logic [7:0] OFF_PUMP_GAIN_CFG = 8'h0e;
	localparam logic [7:0] OFF_FIXED_CFG_C = 8'h0f;
	localparam logic [7:0] OFF_OSC_CURRENT_OVERRIDE = 8'h10;
	localparam logic [7:0] OFF_FIXED_CFG_D = 8'h11;
	localparam logic [7:0] OFF_FIXED_CFG_E = 8'h12;
	localparam logic [7:0] OFF_OSC_BAND_OVERRIDE = 8'h13;
	localparam logic [7:0] OFF_OSC_CORE_SELECT = 8'h14;

	localparam logic [15:0] RST_FORCE_CTRL = 16'h2000;
	localparam logic [15:0] RST_REF_DOUBLER_CFG = 16'h0604;
	localparam logic [15:0] RST_FIXED_CFG_A = 16'h10f8;
	localparam logic [15:0] RST_POST_REF_DIVIDER = 16'h0018;
	localparam logic [15:0] RST_PRE_REF_DIVIDER = 16'h5001;
	localparam logic [15:0] RST_FIXED_CFG_B = 16'h4000;
	localparam logic [15:0] RST_PUMP_GAIN_CFG = 16'h1e70;
	localparam logic [15:0] RST_FIXED_CFG_C = 16'h064f;
	localparam logic [15:0] RST_OSC_CURRENT_OVERRIDE = 16'h0080;
	localparam logic [15:0] RST_FIXED_CFG_D = 16'h0096;
	localparam logic [15:0] RST_FIXED_CFG_E = 16'h0064;
	localparam logic [15:0] RST_OSC_BAND_OVERRIDE = 16'h27b7;
	localparam logic [15:0] RST_OSC_CORE_SELECT = 16'h3048;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_REF_DOUBLER_EN = 12;
	localparam int BIT_OSC_CURRENT_FORCE = 14;
	localparam int BIT_OSC_BAND_FORCE = 11;
	localparam int POST_DIV_LSB = 4;
	localparam int POST_DIV_W = 8;
	localparam int PRE_DIV_LSB = 0;
	localparam int PRE_DIV_W = 8;
	localparam int PUMP_GAIN_LSB = 4;
	localparam int PUMP_GAIN_W = 3;
	localparam int OSC_CURRENT_LSB = 0;
	localparam int OSC_CURRENT_W = 9;
	localparam int OSC_BAND_LSB = 0;
	localparam int OSC_BAND_W = 8;

	// ----------------------------------------
	// Pump gain codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRVC_PUMP_OFF = 3'b000,
		SRVC_PUMP_6MA = 3'b001,
		SRVC_PUMP_BAD2 = 3'b010,
		SRVC_PUMP_12MA = 3'b011,
		SRVC_PUMP_3MA = 3'b100,
		SRVC_PUMP_9MA = 3'b101,
		SRVC_PUMP_BAD6 = 3'b110,
		SRVC_PUMP_15MA = 3'b111
	} srvc_pump_t;

	// ----------------------------------------
	// Bus request and analog-side controls
	// ----------------------------------------
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} srvc_req_t;

	typedef struct packed {
		logic ref_doubler_en;
		logic [POST_DIV_W-1:0] post_ref_div;
		logic [PRE_DIV_W-1:0] pre_ref_div;
		srvc_pump_t pump_gain_code;
		logic pump_tristate;
		logic pump_code_legal;
		logic osc_current_force;
		logic [OSC_CURRENT_W-1:0] osc_current_applied;
		logic osc_band_force;
		logic [OSC_BAND_W-1:0] osc_band_applied;
	} srvc_ctrl_t;
endpackage : srvc_pkg
`default_nettype wire

//--- srvc_regfile.sv
`default_nettype none
module srvc_regfile #(
	parameter int DEPTH = 13,
	parameter int WIDTH = 16,
	parameter logic [DEPTH*WIDTH-1:0] RESET_VALS = '0
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	output logic [DEPTH*WIDTH-1:0] all_q
);
	// ----------------------------------------
	// Storage, one word per entry
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_word
			logic [WIDTH-1:0] word_q;
			always_ff @(posedge clk_sys or negedge resetn)
			begin
				if (!resetn)
					word_q <= RESET_VALS[gi*WIDTH +: WIDTH];
				else if (wr_en && (wr_idx == ($clog2(DEPTH))'(gi)))
					word_q <= wr_data;
			end
			assign all_q[gi*WIDTH +: WIDTH] = word_q;
		end
	endgenerate

	// ----------------------------------------
	// Registered read port
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= all_q[rd_idx*WIDTH +: WIDTH];
		else
			rd_data <= '0;
	end
endmodule : srvc_regfile
`default_nettype wire

//--- srvc_regs.sv
`default_nettype none
// Notes on behaviour
// - Offset 0x9 bit 12 enables reference doubler; resets to 0.
// - Offset 0xB bits 11-4 hold post-reference divider; resets to 1.
// - Offset 0xC bits 7-0 hold pre-reference divider; resets to 1.
// - Offset 0xE bits 6-4 pump gain, reset 7; 0 tri-states pump.
// - Offset 0x10 bits 8-0 oscillator current, reset 0x80, used when forced.
// - Offset 0x13 bits 7-0 oscillator band, used only when forced.
// - Offset 0x8 bit 14 forces programmed oscillator current.
// - Offset 0x8 bit 11 forces programmed oscillator band.
module srvc_regs (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire srvc_pkg::srvc_req_t bus_req,
	output logic [srvc_pkg::DATA_W-1:0] bus_rdata,
	input wire logic [srvc_pkg::OSC_CURRENT_W-1:0] cal_osc_current,
	input wire logic [srvc_pkg::OSC_BAND_W-1:0] cal_osc_band,
	output srvc_pkg::srvc_ctrl_t ctrl
);
	import srvc_pkg::*;

	localparam int IDX_W = $clog2(NUM_REGS);

	// ----------------------------------------
	// Reset image, lowest offset in low word
	// ----------------------------------------
	localparam logic [NUM_REGS*DATA_W-1:0] RESET_IMAGE = {
		RST_OSC_CORE_SELECT,
		RST_OSC_BAND_OVERRIDE,
		RST_FIXED_CFG_E,
		RST_FIXED_CFG_D,
		RST_OSC_CURRENT_OVERRIDE,
		RST_FIXED_CFG_C,
		RST_PUMP_GAIN_CFG,
		RST_FIXED_CFG_B,
		RST_PRE_REF_DIVIDER,
		RST_POST_REF_DIVIDER,
		RST_FIXED_CFG_A,
		RST_REF_DOUBLER_CFG,
		RST_FORCE_CTRL
	};

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic hit;
	logic [ADDR_W-1:0] rel_addr;
	logic [IDX_W-1:0] idx;
	logic rd_hit_q;
	logic [DATA_W-1:0] file_rdata;
	logic [NUM_REGS*DATA_W-1:0] regs_all;

	always_comb
	begin
		rel_addr = bus_req.addr - OFF_FORCE_CTRL;
		hit = (bus_req.addr >= OFF_FORCE_CTRL) && (bus_req.addr <= OFF_OSC_CORE_SELECT);
		idx = rel_addr[IDX_W-1:0];
	end

	// storage: every word read/write with its own reset value
	srvc_regfile #(
		.DEPTH(NUM_REGS),
		.WIDTH(DATA_W),
		.RESET_VALS(RESET_IMAGE)
	) u_file (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_en(bus_req.wr_en && hit),
		.wr_idx(idx),
		.wr_data(bus_req.wdata),
		.rd_en(bus_req.rd_en && hit),
		.rd_idx(idx),
		.rd_data(file_rdata),
		.all_q(regs_all)
	);

	// Unmapped reads return zero
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			rd_hit_q <= 1'b0;
		else
			rd_hit_q <= bus_req.rd_en && hit;
	end

	assign bus_rdata = rd_hit_q ? file_rdata : '0;

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	function automatic logic [DATA_W-1:0] word_at(input logic [7:0] off);
		logic [7:0] rel;
		rel = off - OFF_FORCE_CTRL;
		word_at = regs_all[rel*DATA_W +: DATA_W];
	endfunction : word_at

	logic [DATA_W-1:0] w_force;
	logic [DATA_W-1:0] w_dbl;
	logic [DATA_W-1:0] w_post;
	logic [DATA_W-1:0] w_pre;
	logic [DATA_W-1:0] w_pump;
	logic [DATA_W-1:0] w_cur;
	logic [DATA_W-1:0] w_band;
	logic [PUMP_GAIN_W-1:0] pump_raw;

	always_comb
	begin
		w_force = word_at(OFF_FORCE_CTRL);
		w_dbl = word_at(OFF_REF_DOUBLER_CFG);
		w_post = word_at(OFF_POST_REF_DIVIDER);
		w_pre = word_at(OFF_PRE_REF_DIVIDER);
		w_pump = word_at(OFF_PUMP_GAIN_CFG);
		w_cur = word_at(OFF_OSC_CURRENT_OVERRIDE);
		w_band = word_at(OFF_OSC_BAND_OVERRIDE);
		pump_raw = w_pump[PUMP_GAIN_LSB +: PUMP_GAIN_W];
	end

	// ----------------------------------------
	// Control outputs, registered
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			// Reset image of the registers, as seen one cycle later
			ctrl <= '0;
			ctrl.post_ref_div <= RST_POST_REF_DIVIDER[POST_DIV_LSB +: POST_DIV_W];
			ctrl.pre_ref_div <= RST_PRE_REF_DIVIDER[PRE_DIV_LSB +: PRE_DIV_W];
			ctrl.pump_gain_code <= srvc_pump_t'(RST_PUMP_GAIN_CFG[PUMP_GAIN_LSB +: PUMP_GAIN_W]);
			ctrl.pump_code_legal <= 1'b1;
		end
		else
		begin
			ctrl.ref_doubler_en <= w_dbl[BIT_REF_DOUBLER_EN];
			ctrl.post_ref_div <= w_post[POST_DIV_LSB +: POST_DIV_W];
			ctrl.pre_ref_div <= w_pre[PRE_DIV_LSB +: PRE_DIV_W];
			ctrl.pump_gain_code <= srvc_pump_t'(pump_raw);
			ctrl.pump_tristate <= (pump_raw == SRVC_PUMP_OFF);
			// Undefined codes flagged, but still passed through on pump_gain_code
			ctrl.pump_code_legal <= (pump_raw != SRVC_PUMP_BAD2) && (pump_raw != SRVC_PUMP_BAD6);
			ctrl.osc_current_force <= w_force[BIT_OSC_CURRENT_FORCE];
			ctrl.osc_band_force <= w_force[BIT_OSC_BAND_FORCE];
			ctrl.osc_current_applied <= w_force[BIT_OSC_CURRENT_FORCE]
				? w_cur[OSC_CURRENT_LSB +: OSC_CURRENT_W] : cal_osc_current;
			ctrl.osc_band_applied <= w_force[BIT_OSC_BAND_FORCE]
				? w_band[OSC_BAND_LSB +: OSC_BAND_W] : cal_osc_band;
		end
	end
endmodule : srvc_regs
`default_nettype wire

//--- srvc_regs_monitor.sv
`default_nettype none
module srvc_regs_monitor import srvc_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire srvc_pkg::srvc_req_t bus_req,
	input wire logic [srvc_pkg::DATA_W-1:0] bus_rdata,
	input wire logic [srvc_pkg::OSC_CURRENT_W-1:0] cal_osc_current,
	input wire logic [srvc_pkg::OSC_BAND_W-1:0] cal_osc_band,
	input wire srvc_pkg::srvc_ctrl_t ctrl
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// Bus and control checks
	// ------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic wr;
	logic rd;
	logic [7:0] ad;
	logic [15:0] wd;
	assign wr = bus_req.wr_en;
	assign rd = bus_req.rd_en;
	assign ad = bus_req.addr;
	assign wd = bus_req.wdata;
	property p_rd_idle; !rd |=> bus_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped; rd && !(ad inside {[8'h08:8'h14]}) |=> bus_rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_wr_rd;
		wr && ad inside {[8'h08:8'h14]} ##1 rd && ad == $past(ad) |=> bus_rdata == $past(wd, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("read after write stale");
	property p_dbl; wr && ad == 8'h09 |-> ##2 ctrl.ref_doubler_en == $past(wd[12], 2); endproperty
	a_dbl: assert property (p_dbl) else $error("doubler enable wrong");
	property p_pump; wr && ad == 8'h0e |-> ##2 ctrl.pump_gain_code == $past(wd[6:4], 2); endproperty
	a_pump: assert property (p_pump) else $error("pump gain code wrong");
	property p_flags;
		$past(resetn) |-> ctrl.pump_tristate == (ctrl.pump_gain_code == SRVC_PUMP_OFF) &&
			ctrl.pump_code_legal == !(ctrl.pump_gain_code inside {SRVC_PUMP_BAD2, SRVC_PUMP_BAD6});
	endproperty
	a_flags: assert property (p_flags) else $error("pump flags wrong");
	property p_force;
		wr && ad == 8'h08 |-> ##2
			{ctrl.osc_current_force, ctrl.osc_band_force} == {$past(wd[14], 2), $past(wd[11], 2)};
	endproperty
	a_force: assert property (p_force) else $error("force controls wrong");
	property p_cur_sel;
		$past(resetn) && !ctrl.osc_current_force |-> ctrl.osc_current_applied == $past(cal_osc_current);
	endproperty
	a_cur_sel: assert property (p_cur_sel) else $error("unforced current wrong");
	property p_band_sel;
		$past(resetn) && !ctrl.osc_band_force |-> ctrl.osc_band_applied == $past(cal_osc_band);
	endproperty
	a_band_sel: assert property (p_band_sel) else $error("unforced band wrong");
	c_wr_rd: cover property (wr ##1 rd && ad == $past(ad));
	c_forced: cover property (ctrl.osc_current_force && ctrl.osc_band_force);
	c_bad: cover property ($past(resetn) && !ctrl.pump_code_legal);
endmodule : srvc_regs_monitor
bind srvc_regs srvc_regs_monitor srvc_regs_monitor_inst (.clk_sys(clk_sys), .resetn(resetn),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .cal_osc_current(cal_osc_current),
	.cal_osc_band(cal_osc_band), .ctrl(ctrl));
`default_nettype wire

//--- srvc_regs_test.sv
`default_nettype none
module srvc_regs_test import srvc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	srvc_req_t bus_req = '0;
	logic [DATA_W-1:0] bus_rdata;
	logic [OSC_CURRENT_W-1:0] cal_osc_current = 9'h155;
	logic [OSC_BAND_W-1:0] cal_osc_band = 8'h5a;
	srvc_ctrl_t ctrl;
	int fails = 0;
	int cmp_count = 0;
	logic [15:0] rv [13] = '{16'h2000, 16'h0604, 16'h10f8, 16'h0018, 16'h5001, 16'h4000,
		16'h1e70, 16'h064f, 16'h0080, 16'h0096, 16'h0064, 16'h27b7, 16'h3048};
	always #50 clk_sys = ~clk_sys;
	srvc_regs srvc_regs_inst (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .cal_osc_current(cal_osc_current),
		.cal_osc_band(cal_osc_band), .ctrl(ctrl));
	// ------------------------------
	// Bus tasks
	// ------------------------------
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [15:0] e);
		@(posedge clk_sys);
		bus_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_sys);
		bus_req <= '0;
		@(negedge clk_sys);
		chk("bus_rdata", e, bus_rdata);
	endtask : rd
	task automatic do_reset();
		@(posedge clk_sys);
		resetn <= 1'b0;
		bus_req <= '0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
	endtask : do_reset
	task automatic chk_osc(logic [15:0] c, logic [15:0] b);
		chk("current", c, 16'(ctrl.osc_current_applied));
		chk("band", b, 16'(ctrl.osc_band_applied));
	endtask : chk_osc
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset();
		for (int i = 0; i < 13; i++)
			rd(8'(i + 8), rv[i]);
		chk("doubler", 16'h0000, 16'(ctrl.ref_doubler_en));
		chk("post", 16'h0001, 16'(ctrl.post_ref_div));
		chk("pre", 16'h0001, 16'(ctrl.pre_ref_div));
		chk("pump", 16'h0007, 16'(ctrl.pump_gain_code));
		chk_osc(16'h0155, 16'h005a);
		$display("done reset");
	endtask : t_reset
	task automatic t_rw();
		logic [15:0] d;
		for (int i = 7; i < 22; i++)
		begin
			d = 16'(i * 16'h1111) ^ 16'ha5c3;
			wr(8'(i), d);
			rd(8'(i), (i < 8 || i > 20) ? 16'h0000 : d);
		end
		$display("done rw");
	endtask : t_rw
	task automatic t_fields();
		wr(OFF_FIXED_CFG_A, 16'h10d8);
		wr(OFF_FIXED_CFG_D, 16'h012c);
		wr(OFF_POST_REF_DIVIDER, 16'h0ab8);
		wr(OFF_PRE_REF_DIVIDER, 16'h50cd);
		wr(OFF_REF_DOUBLER_CFG, 16'h1604);
		wr(OFF_FIXED_CFG_B, 16'h4000);
		wr(OFF_FIXED_CFG_C, 16'h064f);
		wr(OFF_FIXED_CFG_E, 16'h0064);
		rd(OFF_FIXED_CFG_A, 16'h10d8);
		rd(OFF_FIXED_CFG_D, 16'h012c);
		rd(OFF_POST_REF_DIVIDER, 16'h0ab8);
		rd(OFF_PRE_REF_DIVIDER, 16'h50cd);
		rd(OFF_REF_DOUBLER_CFG, 16'h1604);
		rd(OFF_FIXED_CFG_B, 16'h4000);
		rd(OFF_FIXED_CFG_C, 16'h064f);
		rd(OFF_FIXED_CFG_E, 16'h0064);
		chk("doubler", 16'h0001, 16'(ctrl.ref_doubler_en));
		chk("post", 16'h00ab, 16'(ctrl.post_ref_div));
		chk("pre", 16'h00cd, 16'(ctrl.pre_ref_div));
		$display("done fields");
	endtask : t_fields
	task automatic t_pump();
		for (int c = 0; c < 8; c++)
		begin
			wr(OFF_PUMP_GAIN_CFG, 16'h1e00 | 16'(c << 4));
			rd(OFF_PUMP_GAIN_CFG, 16'h1e00 | 16'(c << 4));
			chk("pump", 16'(c), 16'(ctrl.pump_gain_code));
			chk("flags", {14'h0, c == 0, c != 2 && c != 6},
				{14'h0, ctrl.pump_tristate, ctrl.pump_code_legal});
		end
		$display("done pump");
	endtask : t_pump
	task automatic t_force();
		wr(OFF_OSC_CURRENT_OVERRIDE, 16'h01a5);
		wr(OFF_OSC_BAND_OVERRIDE, 16'h27b0);
		wr(OFF_FORCE_CTRL, 16'h2000);
		rd(OFF_FORCE_CTRL, 16'h2000);
		chk_osc(16'h0155, 16'h005a);
		wr(OFF_FORCE_CTRL, 16'h6800);
		rd(OFF_FORCE_CTRL, 16'h6800);
		@(posedge clk_sys);
		cal_osc_current <= 9'h0ff;
		cal_osc_band <= 8'h11;
		@(negedge clk_sys);
		chk_osc(16'h01a5, 16'h00b0);
		wr(OFF_FORCE_CTRL, 16'h2800);
		rd(OFF_FORCE_CTRL, 16'h2800);
		chk_osc(16'h00ff, 16'h00b0);
		wr(OFF_FORCE_CTRL, 16'h2000);
		rd(OFF_FORCE_CTRL, 16'h2000);
		chk_osc(16'h00ff, 16'h0011);
		$display("done force");
	endtask : t_force
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial
	begin
		do_reset();
		t_reset();
		t_rw();
		t_fields();
		t_pump();
		t_force();
		do_reset();
		rd(OFF_REF_DOUBLER_CFG, 16'h0604);
		chk_osc(16'h00ff, 16'h0011);
		$display("done second reset");
		end_sim();
	end
endmodule : srvc_regs_test
`default_nettype wire
